// ===== design/bin_scan_pkg.sv
// Package: constants, register map and carrier types for the binary input scanner.
// Assumes a 10 MHz pclk and an APB master with 32-bit data.
package bin_scan_pkg;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          SCAN_US       = 1000;
    localparam int          SCAN_CYCLES   = (CLK_HZ / 1_000_000) * SCAN_US;
    localparam int          NCH           = 16;
    localparam int          EVT_DEPTH     = 50;
    localparam int          TOTAL_W       = 31;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_MODE      = 12'h004;
    localparam logic [11:0] OFS_FILT      = 12'h008;
    localparam logic [11:0] OFS_OSC       = 12'h00C;
    localparam logic [11:0] OFS_STATUS    = 12'h010;
    localparam logic [11:0] OFS_INPUTS    = 12'h014;
    localparam logic [11:0] OFS_VALUES    = 12'h018;
    localparam logic [11:0] OFS_EVT_POP   = 12'h01C;
    localparam logic [11:0] OFS_EVT_TIME  = 12'h020;
    localparam logic [11:0] OFS_TIME      = 12'h024;
    localparam logic [11:0] OFS_TOTAL     = 12'h100;
    localparam logic [11:0] OFS_FROZEN    = 12'h140;
    // Control fields
    localparam int          CTRL_EN_BIT     = 0;
    localparam int          CTRL_FREEZE_BIT = 1;
    localparam int          CTRL_TEST_BIT   = 2;
    localparam int          CTRL_CLROVF_BIT = 3;
    // Mode fields
    localparam int          MODE_FUNC_LSB = 0;
    localparam int          MODE_WIDE_BIT = 4;
    localparam logic [31:0] MODE_RESET    = 32'h0000_0000;
    localparam logic [31:0] FILT_RESET    = 32'h0000_0003;
    localparam logic [31:0] OSC_RESET     = 32'h0000_0A0A;
    // Processing functions
    typedef enum logic [2:0] {
        FN_SINGLE, FN_DOUBLE, FN_MEASURED, FN_STEP, FN_BITSTRING, FN_TOTALS
    } func_t;
    typedef struct packed {
        logic [15:0] time_ms;
        logic [3:0]  channel;
        logic [11:0] value;
    } event_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage

// ===== design/bin_input_filter.sv
// One channel: debounce and oscillation suppression, run once per scan tick.
// Assumes a synchronised input and a one-cycle scan tick.
`timescale 1ns/10ps
module bin_input_filter (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Scan
    input  wire logic       tick,
    input  wire logic       raw,
    input  wire logic [7:0] settle,
    input  wire logic [7:0] osc_limit,
    // Result
    output logic            level,
    output logic            change,
    output logic            blocked
);
    logic [7:0] stable_reg;
    logic [7:0] chg_reg;
    logic [9:0] win_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_reg <= 8'h00;
            level      <= 1'b0;
            change     <= 1'b0;
        end else begin
            change <= 1'b0;
            if (tick) begin
                if (raw == level) begin
                    stable_reg <= 8'h00;
                end else if (stable_reg + 8'h01 >= settle) begin
                    stable_reg <= 8'h00;
                    level      <= raw;
                    change     <= 1'b1;
                end else begin
                    stable_reg <= stable_reg + 8'h01;
                end
            end
        end
    end

    // Oscillation blocking window
    // Changes counted over a 1000-scan window; block clears when a window ends with fewer changes than osc_limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_reg <= 8'h00;
            win_reg <= 10'h000;
            blocked <= 1'b0;
        end else begin
            // Change pulses the cycle after a tick, so it is counted outside the tick gate
            if (change && chg_reg != 8'hFF) begin
                chg_reg <= chg_reg + 8'h01;
            end
            if (tick) begin
                if (win_reg == 10'h3E7) begin
                    win_reg <= 10'h000;
                    chg_reg <= 8'h00;
                    if (chg_reg < osc_limit) begin
                        blocked <= 1'b0;
                    end
                end else begin
                    win_reg <= win_reg + 10'h001;
                    if (osc_limit != 8'h00 && chg_reg >= osc_limit) begin
                        blocked <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

// ===== design/binary_input_scanner.sv
// Binary input scanner: 16 filtered inputs, indications, totals, event queue, APB slave.
// Assumes asynchronous process inputs and an APB master acting as communication unit.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/10ps
module binary_input_scanner
    import bin_scan_pkg::*;
#(
    parameter int SCAN_LEN = SCAN_CYCLES
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Process inputs and indicators
    input  wire logic [NCH-1:0]    process_in,
    output logic [NCH-1:0]         input_activity_leds,
    output logic                   fault_led,
    // Wired-OR attention line toward the unit
    output logic                   attn_out,
    output logic                   attn_oe
);
    ////////////////////////////////////////////////////////////////////////////
    logic [NCH-1:0]     sync1_reg;
    logic [NCH-1:0]     sync2_reg;
    logic [31:0]        ctrl_reg;
    logic [31:0]        mode_reg;
    logic [31:0]        filt_reg;
    logic [31:0]        osc_reg;
    logic [23:0]        div_reg;
    logic               tick;
    logic [15:0]        time_reg;
    logic [NCH-1:0]     level;
    logic [NCH-1:0]     change;
    logic [NCH-1:0]     blocked;
    logic [NCH-1:0]     prev_reg;
    logic [TOTAL_W-1:0] total_reg  [NCH];
    logic [TOTAL_W-1:0] frozen_reg [NCH];
    event_t             queue_reg  [EVT_DEPTH];
    logic [5:0]         rd_reg;
    logic [5:0]         wr_reg;
    logic [5:0]         cnt_reg;
    logic               ovf_reg;
    logic               test_fail_reg;
    logic               init_done_reg;
    logic [15:0]        values_reg;
    logic               valid_reg;
    logic [NCH-1:0]     pair_stable;
    func_t              func;
    logic               wr_acc;
    logic               rd_acc;
    logic               pop;
    logic               push;
    event_t             push_evt;
    apb_req_t           req;

    assign func   = func_t'(mode_reg[MODE_FUNC_LSB +: 3]);
    assign req    = '{psel, penable, pwrite, paddr, pwdata};
    assign wr_acc = req.psel && req.penable && req.pwrite;
    assign rd_acc = req.psel && req.penable && !req.pwrite;
    assign pop    = rd_acc && req.paddr == OFS_EVT_POP && cnt_reg != 6'd0;

    function automatic logic [5:0] wrap_inc(input logic [5:0] p);
        return (p == 6'(EVT_DEPTH - 1)) ? 6'd0 : p + 6'd1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser for the process pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= process_in;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg  <= 24'h000000;
            tick     <= 1'b0;
            time_reg <= 16'h0000;
        end else begin
            tick <= 1'b0;
            if (div_reg == 24'(SCAN_LEN - 1)) begin
                div_reg  <= 24'h000000;
                tick     <= 1'b1;
                time_reg <= time_reg + 16'h0001;
            end else begin
                div_reg <= div_reg + 24'h000001;
            end
        end
    end

    // Per-channel limits from loaded parameters
    // Settle is one byte per group of four channels; the oscillation limit is one byte per group of eight channels
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        bin_input_filter u_filt (
            .pclk      (pclk),
            .presetn   (presetn),
            .tick      (tick),
            .raw       (sync2_reg[i]),
            .settle    (filt_reg[8*(i/4) +: 8]),
            .osc_limit (osc_reg[8*(i/8) +: 8]),
            .level     (level[i]),
            .change    (change[i]),
            .blocked   (blocked[i])
        );
        assign pair_stable[i] = !change[i] && !change[i ^ 1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event generation; one event per cycle, lowest changed channel first
    always_comb begin
        push     = 1'b0;
        push_evt = '0;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (ctrl_reg[CTRL_EN_BIT] && prev_reg[c] != level[c] && !blocked[c]) begin
                unique case (func)
                    FN_SINGLE: begin
                        push     = 1'b1;
                        push_evt = '{time_reg, 4'(c), {11'h000, level[c]}};
                    end
                    FN_DOUBLE: begin
                        if (pair_stable[c] && (level[c] ^ level[c ^ 1])) begin
                            push     = 1'b1;
                            push_evt = '{time_reg, 4'(c & 14), {10'h000, level[c | 1], level[c & 14]}};
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Last reported level; double pair states update only when settled, or while the channel is blocked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (push && push_evt.channel == 4'(c)) begin
                    prev_reg[c] <= level[c];
                    if (func == FN_DOUBLE) begin
                        prev_reg[c ^ 1] <= level[c ^ 1];
                    end
                end else if (func != FN_SINGLE && func != FN_DOUBLE) begin
                    prev_reg[c] <= level[c];
                end else if (blocked[c]) begin
                    prev_reg[c] <= level[c];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fifty-entry event store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_reg  <= 6'd0;
            rd_reg  <= 6'd0;
            cnt_reg <= 6'd0;
            ovf_reg <= 1'b0;
            for (int k = 0; k < EVT_DEPTH; k++) begin
                queue_reg[k] <= '0;
            end
        end else begin
            if (push && cnt_reg != 6'(EVT_DEPTH)) begin
                queue_reg[wr_reg] <= push_evt;
                wr_reg            <= wrap_inc(wr_reg);
            end
            if (pop) begin
                rd_reg <= wrap_inc(rd_reg);
            end
            cnt_reg <= cnt_reg + 6'(push && cnt_reg != 6'(EVT_DEPTH)) - 6'(pop);
            // Set wins over the software clear
            if (push && cnt_reg == 6'(EVT_DEPTH)) begin
                ovf_reg <= 1'b1;
            end else if (wr_acc && req.paddr == OFS_CTRL && req.pwdata[CTRL_CLROVF_BIT]) begin
                ovf_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pulse totals on rising edges
    // Debounced edges, one per scan max
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NCH; c++) begin
                total_reg[c]  <= '0;
                frozen_reg[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (func == FN_TOTALS && ctrl_reg[CTRL_EN_BIT] && change[c] && level[c]) begin
                    total_reg[c] <= total_reg[c] + TOTAL_W'(1);
                end
                if (wr_acc && req.paddr == OFS_CTRL && req.pwdata[CTRL_FREEZE_BIT]) begin
                    frozen_reg[c] <= total_reg[c];
                end
            end
        end
    end

    // Bit strings, 8 or 16
    // Value is latched every scan; change pulses the cycle after the tick, so the no-change gate always passes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            values_reg <= 16'h0000;
            valid_reg  <= 1'b0;
        end else if (tick) begin
            if (func == FN_MEASURED || func == FN_STEP || func == FN_BITSTRING) begin
                if (mode_reg[MODE_WIDE_BIT] && func != FN_STEP) begin
                    valid_reg <= (change == '0) && (blocked == '0);
                    if (change == '0) begin
                        values_reg <= level;
                    end
                end else begin
                    valid_reg <= (change == '0) && (blocked == '0);
                    if (change[7:0] == 8'h00) begin
                        values_reg[7:0] <= level[7:0];
                    end
                    if (change[15:8] == 8'h00) begin
                        values_reg[15:8] <= level[15:8];
                    end
                end
            end else begin
                valid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Init and running self-test
    // Test compares the filtered level with the second synchroniser stage at a tick; level high with input low is a fault, only with channel 0-3 settle zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_done_reg <= 1'b0;
            test_fail_reg <= 1'b0;
        end else begin
            if (tick) begin
                init_done_reg <= 1'b1;
            end
            if (ctrl_reg[CTRL_TEST_BIT] && tick && (level & ~sync2_reg & ~change) != '0 &&
                filt_reg[7:0] == 8'h00) begin
                test_fail_reg <= 1'b1;
            end else if (wr_acc && req.paddr == OFS_CTRL && req.pwdata[CTRL_CLROVF_BIT]) begin
                test_fail_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_activity_leds <= '0;
            fault_led           <= 1'b0;
            attn_out            <= 1'b0;
            attn_oe             <= 1'b0;
        end else begin
            input_activity_leds <= level;
            fault_led           <= test_fail_reg || ovf_reg;
            attn_out            <= 1'b0;
            attn_oe             <= cnt_reg != 6'd0 || test_fail_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration written by the unit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 32'h0000_0000;
            mode_reg <= MODE_RESET;
            filt_reg <= FILT_RESET;
            osc_reg  <= OSC_RESET;
        end else if (wr_acc) begin
            unique case (req.paddr)
                OFS_CTRL: ctrl_reg <= {29'h0, req.pwdata[CTRL_TEST_BIT], 1'b0, req.pwdata[CTRL_EN_BIT]};
                OFS_MODE: mode_reg <= {27'h0, req.pwdata[4:0]};
                OFS_FILT: filt_reg <= req.pwdata;
                OFS_OSC:  osc_reg  <= req.pwdata;
                default: begin
                end
            endcase
        end
    end

    // APB answer: zero wait states, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= req.psel && !req.penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (req.psel && !req.penable) begin
                if (req.paddr >= OFS_TOTAL && req.paddr < OFS_TOTAL + 12'h040 && !req.pwrite) begin
                    prdata <= {1'b0, total_reg[req.paddr[5:2]]};
                end else if (req.paddr >= OFS_FROZEN && req.paddr < OFS_FROZEN + 12'h040 && !req.pwrite) begin
                    prdata <= {1'b0, frozen_reg[req.paddr[5:2]]};
                end else begin
                    unique case (req.paddr)
                        OFS_CTRL:     prdata <= ctrl_reg;
                        OFS_MODE:     prdata <= mode_reg;
                        OFS_FILT:     prdata <= filt_reg;
                        OFS_OSC:      prdata <= osc_reg;
                        OFS_STATUS:   prdata <= {16'h0, blocked[7:0], 2'b00, cnt_reg};
                        OFS_INPUTS:   prdata <= {blocked, level};
                        OFS_VALUES:   prdata <= {test_fail_reg, ovf_reg, init_done_reg, 12'h0, valid_reg, values_reg};
                        OFS_EVT_POP:  prdata <= {cnt_reg != 6'd0, 3'b000, queue_reg[rd_reg].channel,
                                                 12'h000, queue_reg[rd_reg].value};
                        OFS_EVT_TIME: prdata <= {16'h0, queue_reg[rd_reg].time_ms};
                        OFS_TIME:     prdata <= {16'h0, time_reg};
                        default:      pslverr <= 1'b1;
                    endcase
                end
            end
        end
    end
endmodule

// ===== dv/bin_scan_props.sv
// Checker: bus timing, error and wired-OR rules of the scanner.
// Assumes it is bound to the scanner top and sees only its ports.
`timescale 1ns/10ps
module bin_scan_props
    import bin_scan_pkg::*;
#(
    parameter int SCAN_LEN = SCAN_CYCLES
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        fault_led,
    input wire logic        attn_out,
    input wire logic        attn_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    chk_ready_after_setup: assert property (
        psel && !penable |=> pready && psel && penable) else $error("no answer after setup");
    chk_ready_one_cycle: assert property (
        pready |=> !pready) else $error("ready held too long");
    chk_ready_in_access: assert property (
        pready |-> psel && penable && $past(psel && !penable)) else $error("ready outside access");
    chk_err_with_ready: assert property (
        pslverr |-> pready) else $error("error without ready");
    chk_err_on_hole: assert property (
        psel && !penable && paddr == 12'h080 |=> pslverr) else $error("hole not refused");
    chk_mapped_no_err: assert property (
        psel && !penable && paddr <= OFS_TIME |=> !pslverr) else $error("mapped word refused");
    chk_err_range: assert property (
        pslverr |-> (paddr > OFS_TIME && paddr < OFS_TOTAL) || paddr >= 12'h180) else $error("bad error");
    chk_attn_never_high: assert property (
        !attn_out) else $error("attention line driven high");
    cover property (pslverr);
    cover property ($rose(fault_led));
    cover property ($fell(attn_oe));
endmodule
bind binary_input_scanner bin_scan_props #(.SCAN_LEN(SCAN_LEN)) i_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .fault_led(fault_led), .attn_out(attn_out), .attn_oe(attn_oe));

// ===== dv/comm_unit_model.sv
// Communication unit model: APB master and wired-OR attention line.
// Assumes the scanner answers each access; a hang marks it dead.
`timescale 1ns/10ps
module comm_unit_model
    import bin_scan_pkg::*;
(
    input  wire logic        pclk,
    output apb_req_t         req,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        attn_out,
    input  wire logic        attn_oe,
    output logic             attn_line,
    output logic             dead
);
    assign attn_line = attn_oe ? attn_out : 1'b1;
    initial begin
        req  = '0;
        dead = 1'b0;
    end
    // Bus load, dead check
    // Waits for the answer however long; only the bench watchdog ends a hang
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            if (n == 50) dead <= 1'b1;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask
endmodule

// ===== dv/binary_input_scanner_bench.sv
// Bench: scenarios for indications, filters, totals and event queue.
// Assumes the scan length is shortened to SL cycles.
`timescale 1ns/10ps
module binary_input_scanner_bench;
    import bin_scan_pkg::*;
    localparam int SL = 20;
    logic            pclk;
    logic            presetn;
    logic [NCH-1:0]  process_in;
    logic [NCH-1:0]  leds;
    logic [31:0]     prdata;
    logic [31:0]     rv;
    logic [31:0]     t1;
    logic            pready;
    logic            pslverr;
    logic            fault_led;
    logic            attn_out;
    logic            attn_oe;
    logic            attn_line;
    logic            dead;
    logic            er;
    apb_req_t        req;
    int              miscompares = 0;
    int              compares = 0;
    binary_input_scanner #(.SCAN_LEN(SL)) i_dut (.pclk(pclk), .presetn(presetn), .psel(req.psel),
        .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .process_in(process_in),
        .input_activity_leds(leds), .fault_led(fault_led), .attn_out(attn_out), .attn_oe(attn_oe));
    comm_unit_model i_unit (.pclk(pclk), .req(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .attn_out(attn_out), .attn_oe(attn_oe), .attn_line(attn_line), .dead(dead));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_unit.xfer(1'b1, a, d, rv, er);
    endtask
    task automatic rd(input logic [11:0] a);
        i_unit.xfer(1'b0, a, 32'h0, rv, er);
    endtask
    task automatic scans(input int n);
        repeat (n * SL) @(posedge pclk);
    endtask
    task automatic setin(input logic [15:0] v);
        @(posedge pclk);
        process_in <= v;
    endtask
    task automatic pop_chk(input logic [31:0] exp);
        rd(OFS_EVT_POP);
        check(exp, rv & 32'h8F00_0FFF);
    endtask
    task automatic drain();
        int n;
        n = 0;
        do begin
            rd(OFS_EVT_POP);
            n++;
        end while (rv[31] === 1'b1 && n < 60);
    endtask
    task automatic print_verdict();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(OFS_MODE);
        check(MODE_RESET, rv);
        rd(OFS_FILT);
        check(FILT_RESET, rv);
        rd(OFS_OSC);
        check(OSC_RESET, rv);
        rd(OFS_VALUES);
        check(32'h2000_0000, rv & 32'hE000_0000);
        rd(12'h080);
        check(32'h1, {31'h0, er});
    endtask
    task automatic t_single();
        wr(OFS_FILT, 32'h0);
        wr(OFS_OSC, 32'h0);
        wr(OFS_CTRL, 32'h1);
        drain();
        setin(16'h0008);
        scans(3);
        setin(16'h0208);
        scans(3);
        check(32'h0208, {16'h0, leds});
        rd(OFS_EVT_TIME);
        t1 = rv;
        pop_chk(32'h8300_0001);
        rd(OFS_EVT_TIME);
        check(32'h1, {31'h0, t1[15:0] < rv[15:0]});
        pop_chk(32'h8900_0001);
        setin(16'h0);
        scans(3);
        drain();
    endtask
    task automatic t_bounce();
        wr(OFS_FILT, 32'h3);
        repeat (3) begin
            setin(16'h1);
            scans(1);
            setin(16'h0);
            scans(1);
        end
        pop_chk(32'h0);
        setin(16'h1);
        scans(6);
        check(32'h1, {31'h0, leds[0]});
        pop_chk(32'h8000_0001);
        setin(16'h0);
        scans(6);
        wr(OFS_FILT, 32'h0);
        drain();
    endtask
    task automatic t_totals();
        wr(OFS_MODE, 32'h5);
        for (int i = 0; i < 6; i++) begin
            setin(16'h4);
            scans(20);
            setin(16'h0);
            scans(20);
            // Freeze once, after the first pulse only
            if (i == 0) wr(OFS_CTRL, 32'h3);
            rd(OFS_TOTAL + 12'h008);
        end
        check(32'h6, rv);
        rd(OFS_FROZEN + 12'h008);
        check(32'h1, rv);
    endtask
    task automatic t_measured();
        wr(OFS_MODE, 32'h12);
        setin(16'hA5C3);
        scans(3);
        rd(OFS_VALUES);
        check(32'h0001_A5C3, rv & 32'h0001_FFFF);
        setin(16'h0);
        scans(3);
    endtask
    task automatic t_step_bits();
        wr(OFS_MODE, 32'h3);
        setin(16'h5A3C);
        scans(3);
        rd(OFS_VALUES);
        check(32'h0001_5A3C, rv & 32'h0001_FFFF);
        wr(OFS_MODE, 32'h4);
        setin(16'hC35A);
        scans(3);
        rd(OFS_VALUES);
        check(32'h0001_C35A, rv & 32'h0001_FFFF);
        setin(16'h0);
        scans(3);
    endtask
    task automatic t_double();
        wr(OFS_MODE, 32'h1);
        setin(16'h1);
        scans(3);
        setin(16'h3);
        scans(3);
        setin(16'h2);
        scans(3);
        pop_chk(32'h8000_0001);
        pop_chk(32'h8000_0002);
        pop_chk(32'h0);
        setin(16'h0);
        scans(3);
    endtask
    task automatic t_overflow();
        wr(OFS_MODE, 32'h0);
        drain();
        repeat (4) begin
            setin(16'hFFFF);
            scans(2);
            setin(16'h0);
            scans(2);
        end
        rd(OFS_STATUS);
        check(32'd50, {26'h0, rv[5:0]});
        check(32'h1, {31'h0, fault_led});
        check(32'h0, {31'h0, attn_line});
        pop_chk(32'h8000_0001);
        wr(OFS_CTRL, 32'h9);
        // Clear lands at the access edge; the registered LED follows one edge later
        repeat (2) @(posedge pclk);
        check(32'h0, {31'h0, fault_led});
        drain();
        scans(1);
        check(32'h1, {31'h0, attn_line});
    endtask
    task automatic t_osc();
        wr(OFS_OSC, 32'h2);
        repeat (6) begin
            setin(16'h2);
            scans(2);
            setin(16'h0);
            scans(2);
        end
        rd(OFS_INPUTS);
        check(32'h1, {31'h0, rv[17]});
        check(32'h0, {31'h0, dead});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        miscompares++;
        print_verdict();
    end
    initial begin
        presetn = 1'b0;
        process_in = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        scans(2);
        t_regs();
        t_single();
        t_bounce();
        t_totals();
        t_measured();
        t_step_bits();
        t_double();
        t_overflow();
        t_osc();
        print_verdict();
    end
endmodule
